// ---- ext_irq_pkg.sv ----
package ext_irq_pkg;

    // register byte addresses on the apb port
    localparam logic [7:0] ADDR_SENSE    = 8'h00;
    localparam logic [7:0] ADDR_ENABLE   = 8'h04;
    localparam logic [7:0] ADDR_FLAGS    = 8'h08;
    localparam logic [7:0] ADDR_PC_CTRL  = 8'h0C;
    localparam logic [7:0] ADDR_PC_FLAGS = 8'h10;
    localparam logic [7:0] ADDR_PC_MASK0 = 8'h14;
    localparam logic [7:0] ADDR_PC_MASK1 = 8'h18;
    localparam logic [7:0] ADDR_PC_MASK2 = 8'h1C;

    // writable bits of each register, all others read zero
    localparam logic [7:0] WMASK_SENSE = 8'h0F;
    localparam logic [7:0] WMASK_EXT   = 8'h03;
    localparam logic [7:0] WMASK_GROUP = 8'h07;
    localparam logic [7:0] WMASK_MASK1 = 8'h7F;
    localparam logic [7:0] WMASK_FULL  = 8'hFF;

    // reset values
    localparam logic [7:0] RESET_REG = 8'h00;

    // field positions in the sense register
    localparam int SENSE_A_LSB = 0;
    localparam int SENSE_B_LSB = 2;

    // positions of the external pins in the sampled vector
    localparam int POS_EXT_A = 0;
    localparam int POS_EXT_B = 1;
    localparam int POS_PC    = 2;

    // fill cycles before the filtered levels are trusted
    localparam logic [1:0] PRIME_CYCLES = 2'h3;

    // sense modes
    localparam logic [1:0] SENSE_LOW  = 2'h0;
    localparam logic [1:0] SENSE_ANY  = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

    // one bit per interrupt source, used for requests and acknowledges
    typedef struct packed {
        logic [2:0] pin_change;
        logic       ext_b;
        logic       ext_a;
    } irq_vec_type;

endpackage

// ---- external_pin_interrupt_unit.sv ----
`timescale 1ns/1ps
`default_nettype none

module external_pin_interrupt_unit #(
    parameter int PIN_CHANGE_WIDTH = 24
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic                      clk_en,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      ext_irq_a,
    input  wire logic                      ext_irq_b,
    input  wire logic [PIN_CHANGE_WIDTH-1:0] pin_change_inputs,
    input  wire logic                      global_irq_enable,
    input  wire ext_irq_pkg::irq_vec_type  vector_ack,
    output ext_irq_pkg::irq_vec_type       irq_request,
    output logic                           wake_request
);

    localparam int VW = PIN_CHANGE_WIDTH + 2;

    // the group layout is fixed at three groups of eight
    if (PIN_CHANGE_WIDTH != 24) begin : g_width_check
        $error("PIN_CHANGE_WIDTH must be 24");
    end

    ////////////////////////////////////////////////////////////////////////////
    // sense decoding, shared by both external pins
    function automatic logic edge_trigger(input logic [1:0] mode, input logic chg, input logic lvl);
        logic hit;
        hit = 1'b0;
        unique case (mode)
            ext_irq_pkg::SENSE_LOW:  hit = 1'b0;
            ext_irq_pkg::SENSE_ANY:  hit = chg;
            ext_irq_pkg::SENSE_FALL: hit = chg & ~lvl;
            ext_irq_pkg::SENSE_RISE: hit = chg & lvl;
        endcase
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] sense;
    logic [7:0] ext_enable;
    logic [1:0] ext_flag;
    logic [7:0] group_enable;
    logic [2:0] pc_flag;
    logic [7:0] pc_mask [3];

    ////////////////////////////////////////////////////////////////////////////
    // pin sampling: three stages, a pin-change level counts once stages two and three agree, external pins take stage three
    logic [VW-1:0] raw_pins;
    logic [VW-1:0] sync1;
    logic [VW-1:0] sync2;
    logic [VW-1:0] sync3;
    logic [VW-1:0] pin_level;
    logic [VW-1:0] prev_level;
    logic [VW-1:0] next_pin_level;
    logic [VW-1:0] pin_changed;
    logic [1:0]    prime_count;
    logic          primed;

    // sampled-vector bits that belong to the two external pins
    localparam logic [VW-1:0] EXT_PINS = (VW'(1) << ext_irq_pkg::POS_EXT_A) | (VW'(1) << ext_irq_pkg::POS_EXT_B);

    // the pins are read as inputs whatever their port direction
    assign raw_pins       = {pin_change_inputs, ext_irq_b, ext_irq_a};
    // the external pins take stage three alone, so a pulse caught at a single edge is not lost;
    // pin-change inputs keep the agreement filter against glitches
    assign next_pin_level = (EXT_PINS & sync3)
                          | (~EXT_PINS & (sync2 ~^ sync3) & sync3)
                          | (~EXT_PINS & (sync2 ^ sync3) & pin_level);
    assign primed         = (prime_count == ext_irq_pkg::PRIME_CYCLES);
    assign pin_changed    = primed ? (pin_level ^ prev_level) : '0;

    // synchroniser and filtered level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1      <= '0;
            sync2      <= '0;
            sync3      <= '0;
            pin_level  <= '0;
            prev_level <= '0;
        end else if (clk_en) begin
            sync1      <= raw_pins;
            sync2      <= sync1;
            sync3      <= sync2;
            pin_level  <= next_pin_level;
            prev_level <= pin_level;
        end
    end

    // no edges are reported until the pipeline holds real pin values
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prime_count <= 2'h0;
        end else if (clk_en && !primed) begin
            prime_count <= prime_count + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // external pin trigger decode
    logic [1:0] sense_a;
    logic [1:0] sense_b;
    logic [1:0] ext_level_mode;
    logic [1:0] ext_set;
    logic [1:0] ext_low;

    assign sense_a = sense[ext_irq_pkg::SENSE_A_LSB +: 2];
    assign sense_b = sense[ext_irq_pkg::SENSE_B_LSB +: 2];
    assign ext_level_mode = {sense_b == ext_irq_pkg::SENSE_LOW, sense_a == ext_irq_pkg::SENSE_LOW};
    // edges come from the clocked samples, so they need the clock running
    assign ext_set[0] = edge_trigger(sense_a, pin_changed[ext_irq_pkg::POS_EXT_A],
                                     pin_level[ext_irq_pkg::POS_EXT_A]);
    assign ext_set[1] = edge_trigger(sense_b, pin_changed[ext_irq_pkg::POS_EXT_B],
                                     pin_level[ext_irq_pkg::POS_EXT_B]);
    // live filtered level, so a level that vanishes before start-up asks nothing
    assign ext_low = ~pin_level[ext_irq_pkg::POS_EXT_B:ext_irq_pkg::POS_EXT_A]
                     & ext_level_mode;

    ////////////////////////////////////////////////////////////////////////////
    // pin change groups
    logic [2:0] pc_set;
    logic [2:0] pc_async;
    logic [2:0] pc_wake;

    for (genvar g = 0; g < 3; g++) begin : g_group
        logic [7:0] grp_chg;
        logic [7:0] grp_raw;
        assign grp_chg    = pin_changed[ext_irq_pkg::POS_PC + 8*g +: 8];
        // raw pin against last filtered value needs no clock edge to show a change
        assign grp_raw    = raw_pins[ext_irq_pkg::POS_PC + 8*g +: 8]
                            ^ pin_level[ext_irq_pkg::POS_PC + 8*g +: 8];
        assign pc_set[g]  = |(grp_chg & pc_mask[g]);
        assign pc_async[g] = |(grp_raw & pc_mask[g]);
        assign pc_wake[g] = pc_async[g] & group_enable[g];
    end

    // wake works while the clock is stopped
    assign wake_request = (|pc_wake)
        | (|(~raw_pins[ext_irq_pkg::POS_EXT_B:ext_irq_pkg::POS_EXT_A]
             & ext_level_mode & ext_enable[1:0]));

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    logic       setup_phase;
    logic       access_phase;
    logic       addr_hit;
    logic       reg_write;
    logic [7:0] wdata;
    logic [7:0] read_mux;

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign wdata        = pwdata[7:0];
    assign addr_hit     = (paddr == ext_irq_pkg::ADDR_SENSE)   || (paddr == ext_irq_pkg::ADDR_ENABLE)
                       || (paddr == ext_irq_pkg::ADDR_FLAGS)   || (paddr == ext_irq_pkg::ADDR_PC_CTRL)
                       || (paddr == ext_irq_pkg::ADDR_PC_FLAGS) || (paddr == ext_irq_pkg::ADDR_PC_MASK0)
                       || (paddr == ext_irq_pkg::ADDR_PC_MASK1) || (paddr == ext_irq_pkg::ADDR_PC_MASK2);
    assign reg_write    = access_phase & pwrite & addr_hit & clk_en;
    // a frozen block holds the bus in its access phase
    assign pready       = clk_en;
    assign pslverr      = access_phase & ~addr_hit;

    // read selection, unused bits come back as zero
    assign read_mux =
        (paddr == ext_irq_pkg::ADDR_SENSE)    ? sense :
        (paddr == ext_irq_pkg::ADDR_ENABLE)   ? ext_enable :
        (paddr == ext_irq_pkg::ADDR_FLAGS)    ? {6'h00, ext_flag} :
        (paddr == ext_irq_pkg::ADDR_PC_CTRL)  ? group_enable :
        (paddr == ext_irq_pkg::ADDR_PC_FLAGS) ? {5'h00, pc_flag} :
        (paddr == ext_irq_pkg::ADDR_PC_MASK0) ? pc_mask[0] :
        (paddr == ext_irq_pkg::ADDR_PC_MASK1) ? pc_mask[1] :
        (paddr == ext_irq_pkg::ADDR_PC_MASK2) ? pc_mask[2] : 8'h00;

    // read data captured at the end of the setup cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && setup_phase) begin
            prdata <= {24'h00_0000, read_mux};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers, writable bits only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sense        <= ext_irq_pkg::RESET_REG;
            ext_enable   <= ext_irq_pkg::RESET_REG;
            group_enable <= ext_irq_pkg::RESET_REG;
            pc_mask[0]   <= ext_irq_pkg::RESET_REG;
            pc_mask[1]   <= ext_irq_pkg::RESET_REG;
            pc_mask[2]   <= ext_irq_pkg::RESET_REG;
        end else if (reg_write) begin
            if (paddr == ext_irq_pkg::ADDR_SENSE)    sense        <= wdata & ext_irq_pkg::WMASK_SENSE;
            if (paddr == ext_irq_pkg::ADDR_ENABLE)   ext_enable   <= wdata & ext_irq_pkg::WMASK_EXT;
            if (paddr == ext_irq_pkg::ADDR_PC_CTRL)  group_enable <= wdata & ext_irq_pkg::WMASK_GROUP;
            if (paddr == ext_irq_pkg::ADDR_PC_MASK0) pc_mask[0]   <= wdata & ext_irq_pkg::WMASK_FULL;
            if (paddr == ext_irq_pkg::ADDR_PC_MASK1) pc_mask[1]   <= wdata & ext_irq_pkg::WMASK_MASK1;
            if (paddr == ext_irq_pkg::ADDR_PC_MASK2) pc_mask[2]   <= wdata & ext_irq_pkg::WMASK_FULL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags: a set in the clearing cycle wins
    logic [1:0] ext_clr;
    logic [2:0] pc_clr;
    logic [1:0] next_ext_flag;
    logic [2:0] next_pc_flag;

    assign ext_clr = {vector_ack.ext_b, vector_ack.ext_a}
                   | ({2{reg_write && paddr == ext_irq_pkg::ADDR_FLAGS}} & wdata[1:0]);
    assign pc_clr  = vector_ack.pin_change
                   | ({3{reg_write && paddr == ext_irq_pkg::ADDR_PC_FLAGS}} & wdata[2:0]);
    assign next_ext_flag = (ext_set | (ext_flag & ~ext_clr)) & ~ext_level_mode;
    assign next_pc_flag  = pc_set | (pc_flag & ~pc_clr);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_flag <= 2'h0;
            pc_flag  <= 3'h0;
        end else if (clk_en) begin
            ext_flag <= next_ext_flag;
            pc_flag  <= next_pc_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // requests toward the core, each on its own vector line
    assign irq_request.ext_a = (ext_flag[0] | ext_low[0]) & ext_enable[0] & global_irq_enable;
    assign irq_request.ext_b = (ext_flag[1] | ext_low[1]) & ext_enable[1] & global_irq_enable;
    assign irq_request.pin_change = pc_flag & group_enable[2:0] & {3{global_irq_enable}};

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_rise_sets_a: assert property (
        (clk_en && sense_a == ext_irq_pkg::SENSE_RISE && primed && pin_level[0] && !prev_level[0])
        |=> ext_flag[0])
        else $error("rising edge on pin a did not set its flag");

    chk_fall_sets_b: assert property (
        (clk_en && sense_b == ext_irq_pkg::SENSE_FALL && primed && !pin_level[1] && prev_level[1])
        |=> ext_flag[1])
        else $error("falling edge on pin b did not set its flag");

    chk_rise_ignores_fall: assert property (
        (clk_en && sense_a == ext_irq_pkg::SENSE_RISE && !ext_flag[0] && !pin_level[0])
        |=> !ext_flag[0])
        else $error("pin a flag set without a rising edge");

    chk_level_request: assert property (
        (ext_enable[0] && global_irq_enable && sense_a == ext_irq_pkg::SENSE_LOW && !pin_level[0])
        |-> irq_request.ext_a)
        else $error("low level on pin a gives no request");

    chk_level_flag_clear: assert property (
        (clk_en && sense_b == ext_irq_pkg::SENSE_LOW) |=> !ext_flag[1])
        else $error("pin b flag set in low-level mode");

    chk_group0_flag: assert property (
        (clk_en && |(pin_changed[9:2] & pc_mask[0])) |=> pc_flag[0])
        else $error("masked change in group 0 did not set its flag");

    chk_mask_blocks: assert property (
        (clk_en && pc_mask[2] == 8'h00 && !pc_flag[2]) |=> !pc_flag[2])
        else $error("group 2 flag set with all inputs masked");

    chk_global_gate: assert property (
        !global_irq_enable |-> irq_request == '0)
        else $error("request while global enable is low");

    chk_ack_clears: assert property (
        (clk_en && vector_ack.ext_a && ext_flag[0] && !ext_set[0]) |=> !ext_flag[0])
        else $error("acknowledge did not clear pin a flag");

    chk_reserved_zero: assert property (
        (clk_en && setup_phase && paddr == ext_irq_pkg::ADDR_FLAGS) |=> prdata[7:2] == 6'h00)
        else $error("reserved flag bits read nonzero");

    chk_async_wake: assert property (
        (group_enable[1] && pc_mask[1][0] && raw_pins[10] != pin_level[10]) |-> wake_request)
        else $error("pin change without wake request");

    ////////////////////////////////////////////////////////////////////////////
    // external pin flags and requests
    chk_short_pulse: assert property (
        (clk_en && primed && sense_a == ext_irq_pkg::SENSE_ANY && sync3[0] != pin_level[0])
        ##1 (clk_en && sense_a == ext_irq_pkg::SENSE_ANY) |=> ext_flag[0])
        else $error("single sampled change on pin a set no flag");

    chk_set_wins: assert property (
        (clk_en && ext_set[1] && !ext_level_mode[1]) |=> ext_flag[1])
        else $error("pin b trigger lost against a clear");

    chk_write_one_clears: assert property (
        (reg_write && paddr == ext_irq_pkg::ADDR_FLAGS && wdata[1] && !ext_set[1]) |=> !ext_flag[1])
        else $error("written one did not clear pin b flag");

    chk_level_flag_a: assert property (
        (clk_en && sense_a == ext_irq_pkg::SENSE_LOW) |=> !ext_flag[0])
        else $error("pin a flag set in low-level mode");

    chk_flag_from_sync: assert property (
        (!ext_flag[0] && !pin_changed[0]) |=> !ext_flag[0])
        else $error("pin a flag set without a synchronised change");

    chk_enable_gate: assert property (
        !ext_enable[1] |-> !irq_request.ext_b)
        else $error("pin b request while its enable is off");

    chk_level_wake: assert property (
        (ext_enable[0] && sense_a == ext_irq_pkg::SENSE_LOW && !ext_irq_a) |-> wake_request)
        else $error("low level on pin a gives no wake");

    ////////////////////////////////////////////////////////////////////////////
    // pin change groups and the frozen clock
    chk_group2_flag: assert property (
        (clk_en && |(pin_changed[25:18] & pc_mask[2])) |=> pc_flag[2])
        else $error("masked change in group 2 did not set its flag");

    chk_group1_flag: assert property (
        (clk_en && |(pin_changed[17:10] & pc_mask[1])) |=> pc_flag[1])
        else $error("masked change in group 1 did not set its flag");

    chk_group_ack: assert property (
        (clk_en && vector_ack.pin_change[0] && !pc_set[0]) |=> !pc_flag[0])
        else $error("acknowledge did not clear group 0 flag");

    chk_group_gate: assert property (
        (pc_flag[1] && group_enable[1] && global_irq_enable) |-> irq_request.pin_change[1])
        else $error("group 1 flag with both enables gives no request");

    chk_frozen_flags: assert property (
        !clk_en |=> ($stable(ext_flag) && $stable(pc_flag)))
        else $error("flags changed while the clock was held");

endmodule
`default_nettype wire

// ---- pin_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// stands for the pins and the core's interrupt logic
module pin_core_model (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire logic [25:0]              pin_cmd,
    input  wire logic                     gie_cmd,
    input  wire logic                     auto_ack,
    input  wire ext_irq_pkg::irq_vec_type irq_request,
    output logic                          ext_irq_a,
    output logic                          ext_irq_b,
    output logic      [23:0]              pin_change_inputs,
    output logic                          global_irq_enable,
    output ext_irq_pkg::irq_vec_type      vector_ack
);
    logic [4:0] pend;
    logic [4:0] req;

    // the core takes the lowest pending request first
    assign req  = irq_request;
    assign pend = req & ~(req - 5'h01);

    // pins change just after an edge and keep their level until told otherwise
    always_ff @(posedge clk_sys) begin
        ext_irq_a         <= pin_cmd[ext_irq_pkg::POS_EXT_A];
        ext_irq_b         <= pin_cmd[ext_irq_pkg::POS_EXT_B];
        pin_change_inputs <= pin_cmd[25:ext_irq_pkg::POS_PC];
        global_irq_enable <= gie_cmd;
    end

    // one-cycle vector pulse, never two in a row
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vector_ack <= 5'h00;
        end else begin
            vector_ack <= (auto_ack && vector_ack == 5'h00) ? pend : 5'h00;
        end
    end
endmodule
`default_nettype wire

// ---- external_pin_interrupt_unit_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
module external_pin_interrupt_unit_tb_top;
    typedef struct packed {
        logic       ch;
        logic [1:0] mode;
        logic       p0;
        logic       p1;
        logic       exp;
    } row_type;

    logic                     clk_sys;
    logic                     rst_n;
    logic                     clk_en;
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [7:0]               paddr;
    logic [31:0]              pwdata;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic                     ext_irq_a;
    logic                     ext_irq_b;
    logic [23:0]              pin_change_inputs;
    logic                     global_irq_enable;
    ext_irq_pkg::irq_vec_type vector_ack;
    ext_irq_pkg::irq_vec_type irq_request;
    logic                     wake_request;
    logic [25:0]              pin_cmd;
    logic                     gie_cmd;
    logic                     auto_ack;
    logic [4:0]               req_bits;
    logic [31:0]              rdata;
    logic                     rerr;
    int                       err_count;
    int                       compares;
    row_type                  rows [6];
    logic [15:0]              acc [6];
    row_type                  r;

    assign req_bits = irq_request;

    external_pin_interrupt_unit external_pin_interrupt_unit_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b),
        .pin_change_inputs(pin_change_inputs), .global_irq_enable(global_irq_enable),
        .vector_ack(vector_ack), .irq_request(irq_request), .wake_request(wake_request));

    pin_core_model pin_core_model_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .pin_cmd(pin_cmd), .gie_cmd(gie_cmd),
        .auto_ack(auto_ack), .irq_request(irq_request), .ext_irq_a(ext_irq_a),
        .ext_irq_b(ext_irq_b), .pin_change_inputs(pin_change_inputs),
        .global_irq_enable(global_irq_enable), .vector_ack(vector_ack));

    ////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer: setup, then access until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata   = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            results();
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // clock and hang limit
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        results();
    end

    // main sequence
    initial begin
        rows = '{'{1'b0, 2'h3, 1'b0, 1'b1, 1'b1}, '{1'b0, 2'h3, 1'b1, 1'b0, 1'b0},
                 '{1'b1, 2'h2, 1'b1, 1'b0, 1'b1}, '{1'b1, 2'h2, 1'b0, 1'b1, 1'b0},
                 '{1'b0, 2'h1, 1'b1, 1'b0, 1'b1}, '{1'b1, 2'h1, 1'b0, 1'b1, 1'b1}};
        acc  = '{16'h000F, 16'h0403, 16'h0C07, 16'h14FF, 16'h187F, 16'h1CFF};
        err_count = 0;
        compares  = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pin_cmd = 26'h0;
        gie_cmd = 1'b1;
        auto_ack = 1'b0;
        cyc(8);
        rst_n <= 1'b1;
        cyc(8);
        // reset values, then an unmapped place
        for (int k = 0; k < 8; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            check("reset value", rdata, 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped error", 32'(rerr), 32'h1);
        check("unmapped read", rdata, 32'h0);
        $display("reset test done");
        // writable bits of each control register
        foreach (acc[i]) begin
            apb(1'b1, acc[i][15:8], 32'hFFFF_FFFF);
            apb(1'b0, acc[i][15:8], 32'h0);
            check("register bits", rdata, 32'(acc[i][7:0]));
        end
        $display("register test done");
        // edge sense modes on both pins, table driven
        foreach (rows[i]) begin
            r = rows[i];
            pin_cmd[r.ch] <= r.p0;
            cyc(8);
            apb(1'b1, ext_irq_pkg::ADDR_SENSE, 32'(r.mode) << (2 * r.ch));
            apb(1'b1, ext_irq_pkg::ADDR_FLAGS, 32'h3);
            pin_cmd[r.ch] <= r.p1;
            cyc(8);
            check("ext request", 32'(req_bits[r.ch]), 32'(r.exp));
            apb(1'b0, ext_irq_pkg::ADDR_FLAGS, 32'h0);
            check("ext flag", rdata, 32'(r.exp) << r.ch);
            apb(1'b1, ext_irq_pkg::ADDR_FLAGS, 32'h3);
            apb(1'b0, ext_irq_pkg::ADDR_FLAGS, 32'h0);
            check("flag write one", rdata, 32'h0);
        end
        $display("sense table done");
        // low level: request while low, flag held clear, global enable gates
        apb(1'b1, ext_irq_pkg::ADDR_SENSE, 32'h0);
        pin_cmd[1:0] <= 2'b10;
        cyc(8);
        check("level request", 32'(req_bits[0]), 32'h1);
        apb(1'b0, ext_irq_pkg::ADDR_FLAGS, 32'h0);
        check("level flag", rdata, 32'h0);
        gie_cmd <= 1'b0;
        cyc(3);
        check("global gate", 32'(req_bits[0]), 32'h0);
        gie_cmd <= 1'b1;
        pin_cmd[0] <= 1'b1;
        cyc(8);
        check("level released", 32'(req_bits[0]), 32'h0);
        $display("level test done");
        // pin-change groups, a masked pin, then core acknowledge
        apb(1'b1, ext_irq_pkg::ADDR_PC_MASK0, 32'h08);
        apb(1'b1, ext_irq_pkg::ADDR_PC_MASK1, 32'h01);
        apb(1'b1, ext_irq_pkg::ADDR_PC_MASK2, 32'h01);
        apb(1'b1, ext_irq_pkg::ADDR_PC_FLAGS, 32'h7);
        for (int g = 0; g < 3; g++) begin
            pin_cmd[2 + (g == 0 ? 3 : 8 * g)] <= 1'b1;
            cyc(8);
            check("group request", 32'(req_bits[2 + g]), 32'h1);
            apb(1'b0, ext_irq_pkg::ADDR_PC_FLAGS, 32'h0);
            check("group flag", rdata, (32'h2 << g) - 32'h1);
        end
        pin_cmd[6] <= 1'b1;
        apb(1'b1, ext_irq_pkg::ADDR_PC_FLAGS, 32'h7);
        cyc(8);
        apb(1'b0, ext_irq_pkg::ADDR_PC_FLAGS, 32'h0);
        check("masked pin", rdata, 32'h0);
        pin_cmd[5] <= 1'b0;
        cyc(8);
        auto_ack <= 1'b1;
        cyc(12);
        apb(1'b0, ext_irq_pkg::ADDR_PC_FLAGS, 32'h0);
        check("ack clears", rdata, 32'h0);
        auto_ack <= 1'b0;
        $display("pin change test done");
        // wake without a running clock: low level on pin a, then an unmasked change
        check("wake idle", 32'(wake_request), 32'h0);
        clk_en <= 1'b0;
        pin_cmd[0] <= 1'b0;
        cyc(2);
        check("level wake", 32'(wake_request), 32'h1);
        check("frozen ready", 32'(pready), 32'h0);
        pin_cmd[0] <= 1'b1;
        cyc(2);
        check("level wake gone", 32'(wake_request), 32'h0);
        pin_cmd[5] <= 1'b1;
        cyc(2);
        check("wake", 32'(wake_request), 32'h1);
        clk_en <= 1'b1;
        $display("wake test done");
        results();
    end
endmodule
`default_nettype wire
